// [core/flash_host_cfg.svh]
/*
  Constants for the flash status-polling host: bus timing, command codes and
  status bit positions. Assumes a byte-wide flash on a 50 MHz host clock.
*/
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define FH_CLK_NS 20
`define FH_T_ACC_NS 70
`define FH_T_WP_NS 35
`define FH_T_ACC_CYC ((`FH_T_ACC_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_T_WP_CYC ((`FH_T_WP_NS + `FH_CLK_NS - 1) / `FH_CLK_NS)
`define FH_CNT_W 4
`define FH_SYNC_LAG 2

`define FH_UNLOCK1_ADDR 22'h000AAA
`define FH_UNLOCK2_ADDR 22'h000555
`define FH_UNLOCK1_DATA 8'hAA
`define FH_UNLOCK2_DATA 8'h55
`define FH_PROGRAM_DATA 8'hA0
`define FH_ERASE_SETUP_DATA 8'h80
`define FH_CHIP_ERASE_DATA 8'h10
`define FH_SECTOR_ERASE_DATA 8'h30
`define FH_RESET_DATA 8'hF0
`define FH_PROGRAM_LAST 3'h3
`define FH_ERASE_LAST 3'h5

`define FH_BIT_TOGGLE_ONE 6
`define FH_BIT_TIMEOUT 5
`define FH_BIT_WINDOW 3
`define FH_BIT_TOGGLE_TWO 2
`define FH_TOGGLE_MASK 8'h44

`endif

// [core/flash_host_pkg.sv]
/*
  Types shared by the flash status-polling host: user operations and the
  one-hot state codes of both state machines. Assumes nothing else.
*/
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_SECTOR_ERASE = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_ADD_SECTOR = 3'h4,
    OP_WAIT = 3'h5,
    OP_RESET = 3'h6
  } op_e;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_SETUP = 4'h2,
    C_STROBE = 4'h4,
    C_HOLD = 4'h8
  } cyc_state_e;

  typedef enum logic [12:0] {
    S_IDLE = 13'h0001,
    S_SEQ = 13'h0002,
    S_RD_A = 13'h0004,
    S_RD_B = 13'h0008,
    S_RD_C = 13'h0010,
    S_RD_D = 13'h0020,
    S_PAUSE = 13'h0040,
    S_WIN_PRE = 13'h0080,
    S_ADD_WR = 13'h0100,
    S_WIN_POST = 13'h0200,
    S_OPEN = 13'h0400,
    S_RESET_WR = 13'h0800,
    S_USER_RD = 13'h1000
  } poll_state_e;

endpackage

// [core/flash_bus_cycle.sv]
/*
  One asynchronous flash bus cycle, read or write, driven from registers.
  Assumes the flash data pins arrive unsynchronised and that start_in is only
  raised while no cycle is in progress.
*/
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_ce_n_out
);

  localparam logic [`FH_CNT_W-1:0] WP_CYC = `FH_CNT_W'(`FH_T_WP_CYC);
  localparam logic [`FH_CNT_W-1:0] RD_CYC = `FH_CNT_W'(`FH_T_ACC_CYC + `FH_SYNC_LAG);

  if (`FH_T_ACC_CYC + `FH_SYNC_LAG >= (1 << `FH_CNT_W) || `FH_T_WP_CYC >= (1 << `FH_CNT_W)) begin : g_bad_cnt
    $error("Strobe counts do not fit the cycle counter.");
  end

  cyc_state_e state_q;
  logic [`FH_CNT_W-1:0] cnt_q;
  logic write_q;
  logic [DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic read_ok;

  // The data lines settle during the strobe; only a stable, agreed value is taken.
  assign read_ok = (cnt_q >= RD_CYC) && (dq_s2_q == dq_s3_q);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= C_IDLE;
      cnt_q <= '0;
      write_q <= 1'b0;
    end else begin
      unique case (state_q)
        C_IDLE: begin
          cnt_q <= '0;
          if (start_in) begin
            write_q <= write_in;
            state_q <= C_SETUP;
          end
        end
        C_SETUP: begin
          state_q <= C_STROBE;
        end
        C_STROBE: begin
          cnt_q <= cnt_q + 1'b1;
          if (write_q ? (cnt_q + 1'b1 >= WP_CYC) : read_ok) begin
            state_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          state_q <= C_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      rdata_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= (state_q == C_HOLD);
      if (state_q == C_IDLE && start_in) begin
        flash_addr_out <= addr_in;
        flash_dq_out <= wdata_in;
        flash_dq_oe_out <= write_in;
        flash_ce_n_out <= 1'b0;
      end else if (state_q == C_HOLD) begin
        flash_dq_oe_out <= 1'b0;
        flash_ce_n_out <= 1'b1;
      end
      flash_we_n_out <= !((state_q == C_SETUP && write_q) || (state_q == C_STROBE && write_q && cnt_q + 1'b1 < WP_CYC));
      flash_oe_n_out <= !((state_q == C_SETUP && !write_q) || (state_q == C_STROBE && !write_q && !read_ok));
      if (state_q == C_STROBE && !write_q && read_ok) begin
        rdata_out <= dq_s3_q;
      end
    end
  end

endmodule // flash_bus_cycle

// [core/flash_poll_host.sv]
/*
  Host controller that issues program and erase sequences to a parallel flash
  and follows them through the status bits with the toggle-bit algorithm.
  Assumes a byte-wide flash whose ready/busy pin is pulled up outside and
  whose data pins are resolved by the surroundings from flash_dq_oe_out.
*/
// Operation
// - After a timeout error the host writes the reset command.
// - Host confirms acceptance, then checks erase_window_bit around added sectors.
// - Status reads must address the busy bank.
// - Host reads status twice and compares toggle bits; equal means done.
// - Toggling with timeout_error_bit set: recheck, still toggling means failure.
// - Resumed polling starts again from a fresh double read.
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module flash_poll_host
  import flash_host_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic cmd_valid_in,
  input wire op_e cmd_op_in,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic [DATA_W-1:0] cmd_data_in,
  input wire logic pause_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic fail_out,
  output logic late_out,
  output logic window_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic dev_ready_out,
  output logic [ADDR_W-1:0] flash_addr_out,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_ce_n_out,
  input wire logic ready_busy_n_in
);

  if (DATA_W != 8 || ADDR_W < 12) begin : g_bad_width
    $error("Status bit positions need a byte-wide bus and at least 12 address bits.");
  end

  poll_state_e state_q, state_d;
  op_e op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, first_q, bc_rdata;
  logic [2:0] step_q;
  logic accept_q, adding_q, go_q, launched_q, bc_done, take;
  logic rb_s1_q, rb_s2_q, rb_s3_q;
  logic bc_write;
  logic [ADDR_W-1:0] bc_addr;
  logic [DATA_W-1:0] bc_wdata;
  logic toggled;

  function automatic logic [2:0] seq_last(input op_e op);
    if (op == OP_RESET) begin
      return 3'h0;
    end
    return (op == OP_PROGRAM) ? `FH_PROGRAM_LAST : `FH_ERASE_LAST;
  endfunction

  function automatic logic is_bus_state(input poll_state_e s);
    return s inside {S_SEQ, S_RD_A, S_RD_B, S_RD_C, S_RD_D, S_WIN_PRE, S_ADD_WR, S_WIN_POST, S_RESET_WR, S_USER_RD};
  endfunction

  assign take = cmd_valid_in && cmd_ready_out;
  assign toggled = |((first_q ^ bc_rdata) & `FH_TOGGLE_MASK);

  // Address and data of the cycle about to be launched.
  always_comb begin
    bc_write = state_q inside {S_SEQ, S_ADD_WR, S_RESET_WR};
    bc_addr = addr_q;
    bc_wdata = '0;
    if (state_q == S_ADD_WR) begin
      bc_wdata = `FH_SECTOR_ERASE_DATA;
    end else if (state_q == S_RESET_WR || (state_q == S_SEQ && op_q == OP_RESET)) begin
      bc_wdata = `FH_RESET_DATA;
    end else if (state_q == S_SEQ && step_q == seq_last(op_q)) begin
      bc_wdata = (op_q == OP_PROGRAM) ? wdata_q : (op_q == OP_SECTOR_ERASE) ? `FH_SECTOR_ERASE_DATA : `FH_CHIP_ERASE_DATA;
      if (op_q == OP_CHIP_ERASE) begin
        bc_addr = ADDR_W'(`FH_UNLOCK1_ADDR);
      end
    end else if (state_q == S_SEQ) begin
      unique case (step_q)
        3'h0, 3'h3: begin
          bc_addr = ADDR_W'(`FH_UNLOCK1_ADDR);
          bc_wdata = `FH_UNLOCK1_DATA;
        end
        3'h1, 3'h4: begin
          bc_addr = ADDR_W'(`FH_UNLOCK2_ADDR);
          bc_wdata = `FH_UNLOCK2_DATA;
        end
        default: begin
          bc_addr = ADDR_W'(`FH_UNLOCK1_ADDR);
          bc_wdata = (op_q == OP_PROGRAM) ? `FH_PROGRAM_DATA : `FH_ERASE_SETUP_DATA;
        end
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: begin
        if (take) begin
          unique case (cmd_op_in)
            OP_READ: state_d = S_USER_RD;
            OP_WAIT: state_d = S_RD_A;
            OP_ADD_SECTOR: state_d = S_IDLE;
            default: state_d = S_SEQ;
          endcase
        end
      end
      S_OPEN: begin
        if (take) begin
          unique case (cmd_op_in)
            OP_ADD_SECTOR: state_d = S_WIN_PRE;
            OP_WAIT: state_d = S_RD_A;
            OP_RESET: state_d = S_SEQ;
            default: state_d = S_OPEN;
          endcase
        end
      end
      S_SEQ: if (bc_done && step_q == seq_last(op_q)) state_d = (op_q == OP_RESET) ? S_IDLE : S_RD_A;
      S_RD_A: begin
        if (pause_in && !launched_q && !go_q) begin
          state_d = S_PAUSE;
        end else if (bc_done) begin
          state_d = S_RD_B;
        end
      end
      S_RD_B: begin
        if (bc_done) begin
          if (!toggled) begin
            state_d = S_IDLE;
          end else if (accept_q) begin
            state_d = S_WIN_PRE;
          end else if (bc_rdata[`FH_BIT_TIMEOUT]) begin
            state_d = S_RD_C;
          end else begin
            state_d = S_RD_A;
          end
        end
      end
      S_RD_C: if (bc_done) state_d = S_RD_D;
      S_RD_D: if (bc_done) state_d = toggled ? S_RESET_WR : S_IDLE;
      S_PAUSE: if (!pause_in) state_d = S_RD_A;
      S_WIN_PRE: begin
        if (bc_done) begin
          state_d = (adding_q && !bc_rdata[`FH_BIT_WINDOW]) ? S_ADD_WR : S_OPEN;
        end
      end
      S_ADD_WR: if (bc_done) state_d = S_WIN_POST;
      S_WIN_POST: if (bc_done) state_d = S_OPEN;
      S_RESET_WR: if (bc_done) state_d = S_IDLE;
      S_USER_RD: if (bc_done) state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= S_IDLE;
      cmd_ready_out <= 1'b1;
    end else begin
      state_q <= state_d;
      cmd_ready_out <= (state_d == S_IDLE) || (state_d == S_OPEN);
    end
  end

  // Launch one bus cycle per bus state visit, or one per step of a sequence.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      go_q <= 1'b0;
      launched_q <= 1'b0;
    end else begin
      go_q <= is_bus_state(state_q) && !launched_q && !go_q && !bc_done && !(state_q == S_RD_A && pause_in);
      if (go_q) begin
        launched_q <= 1'b1;
      end else if (bc_done) begin
        launched_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      op_q <= OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      step_q <= '0;
      accept_q <= 1'b0;
      adding_q <= 1'b0;
      first_q <= '0;
    end else begin
      if (take) begin
        op_q <= cmd_op_in;
        addr_q <= cmd_addr_in;
        wdata_q <= cmd_data_in;
        step_q <= '0;
        accept_q <= (cmd_op_in == OP_SECTOR_ERASE);
        adding_q <= (cmd_op_in == OP_ADD_SECTOR);
      end else if (state_q == S_SEQ && bc_done) begin
        step_q <= step_q + 1'b1;
      end
      if (bc_done && (state_q == S_RD_A || state_q == S_RD_C)) begin
        first_q <= bc_rdata;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_out <= 1'b0;
      fail_out <= 1'b0;
      late_out <= 1'b0;
      window_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      done_out <= (state_q != S_IDLE && state_d == S_IDLE) || (state_q != S_OPEN && state_d == S_OPEN)
        || (take && state_d == state_q);
      if (take) begin
        fail_out <= 1'b0;
        late_out <= (state_d == state_q); // A command the open window cannot take is dropped.
      end
      if (state_q == S_RD_D && bc_done && toggled) begin
        fail_out <= 1'b1;
      end
      if (bc_done && (state_q == S_WIN_PRE || state_q == S_WIN_POST)) begin
        window_out <= bc_rdata[`FH_BIT_WINDOW];
        late_out <= adding_q && bc_rdata[`FH_BIT_WINDOW];
      end
      if (bc_done && state_q != S_SEQ && state_q != S_ADD_WR && state_q != S_RESET_WR) begin
        rdata_out <= bc_rdata;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      rb_s3_q <= 1'b1;
      dev_ready_out <= 1'b1;
    end else begin
      rb_s1_q <= ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
      if (rb_s2_q == rb_s3_q) begin
        dev_ready_out <= rb_s3_q;
      end
    end
  end

  flash_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_cycle (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(go_q),
    .write_in(bc_write),
    .addr_in(bc_addr),
    .wdata_in(bc_wdata),
    .done_out(bc_done),
    .rdata_out(bc_rdata),
    .flash_addr_out(flash_addr_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_dq_in(flash_dq_in),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_ce_n_out(flash_ce_n_out)
  );

  sequence reset_write_s;
    ##[1:20] (!flash_we_n_out && flash_dq_oe_out && flash_dq_out == `FH_RESET_DATA);
  endsequence

  a_status_bank_addr: assert property (@(posedge clk_in) disable iff (reset_in)
    (go_q && state_q inside {S_RD_A, S_RD_B, S_RD_C, S_RD_D}) |=> (flash_addr_out == addr_q))
    else $error("Status read not addressed to the busy bank.");
  a_stable_means_done: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == S_RD_B && bc_done && !toggled) |=> (state_q == S_IDLE && done_out && !fail_out))
    else $error("Stable toggle bits did not end polling.");
  a_timeout_recheck: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == S_RD_B && bc_done && toggled && !accept_q && bc_rdata[`FH_BIT_TIMEOUT]) |=> (state_q == S_RD_C))
    else $error("Timeout bit seen but toggle not rechecked.");
  a_fail_sends_reset: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == S_RD_D && bc_done && toggled) |=> (fail_out && state_q == S_RESET_WR) ##0 reset_write_s)
    else $error("Failed operation not followed by the reset command.");
  a_resume_fresh: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == S_PAUSE && !pause_in) |=> (state_q == S_RD_A && !launched_q))
    else $error("Resumed polling did not restart with a double read.");
  a_window_precheck: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == S_WIN_PRE && bc_done && adding_q && bc_rdata[`FH_BIT_WINDOW]) |=> (state_q == S_OPEN && late_out)
      ##1 !go_q)
    else $error("Sector added after the erase window closed.");

endmodule // flash_poll_host

// [bench/flash_dev_model.sv]
/*
  Behavioural model of the byte-wide flash behind the polling host: command
  decoding, embedded program and erase timed in ns, and the status byte.
  Assumes the bench resolves the shared data pins; the model drives ready/busy both high and low.
*/
`timescale 1ns/10ps

module flash_dev_model #(
  parameter int PROG_NS = 1000,
  parameter int ERR_NS = 600,
  parameter int WIN_NS = 2000,
  parameter int ERASE_NS = 3000
) (
  input wire logic [21:0] addr_in,
  input wire logic [7:0] dq_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic ce_n_in,
  output logic [7:0] dq_out,
  output logic ready_busy_n_out
);
  logic [7:0] mem [256];
  logic [7:0] pdata, rd_val, last;
  logic tog1, tog2, err_pend, arm_prog, arm_erase, erasing, sector_mode, drv;
  logic [15:0] sel;
  logic [1:0] bank;
  time busy_until, win_until, err_at;

  function automatic logic busy_now();
    return err_pend || ($time < busy_until);
  endfunction

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    {tog1, tog2, err_pend, arm_prog, arm_erase, erasing, sector_mode, drv} = '0;
    {pdata, rd_val, last, sel, bank} = '0;
    busy_until = 0;
    win_until = 0;
    err_at = 0;
    ready_busy_n_out = 1'b1;
  end

  // The pin reads busy from the last command write until the operation ends.
  always #10 ready_busy_n_out = !busy_now();

  always @(posedge we_n_in) if (!ce_n_in) begin
    if (dq_in == 8'hF0) begin
      {err_pend, tog1, tog2, arm_prog, arm_erase} = '0;
      busy_until = 0;
    end else if (busy_now()) begin
      // Besides the reset command, only an added sector inside the open window is taken while busy.
      if (sector_mode && dq_in == 8'h30 && $time < win_until) begin
        sel[addr_in[15:12]] = 1'b1;
        win_until = $time + WIN_NS;
        busy_until = win_until + ERASE_NS;
      end
    end else if (arm_prog) begin
      arm_prog = 1'b0;
      erasing = 1'b0;
      sector_mode = 1'b0;
      bank = addr_in[21:20];
      pdata = dq_in;
      if (addr_in[11:8] == 4'hF) busy_until = $time + PROG_NS;
      else if ((dq_in & ~mem[addr_in[7:0]]) != 8'h00) begin
        err_pend = 1'b1;
        err_at = $time + ERR_NS;
      end else begin
        mem[addr_in[7:0]] = dq_in;
        busy_until = $time + PROG_NS;
      end
    end else if (arm_erase && (dq_in == 8'h30 || dq_in == 8'h10)) begin
      arm_erase = 1'b0;
      erasing = 1'b1;
      bank = addr_in[21:20];
      sector_mode = (dq_in == 8'h30);
      sel = sector_mode ? (16'h0001 << addr_in[15:12]) : 16'hFFFF;
      win_until = sector_mode ? $time + WIN_NS : $time;
      busy_until = win_until + ERASE_NS;
      for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    end else if (dq_in == 8'hA0) arm_prog = 1'b1;
    else if (dq_in == 8'h80) arm_erase = 1'b1;
  end

  // Status replaces array data only for reads of the busy bank.
  always @(negedge oe_n_in) if (!ce_n_in) begin
    #10;
    if (busy_now() && addr_in[21:20] == bank)
      rd_val = {erasing ? 1'b0 : ~pdata[7], tog1, err_pend && $time >= err_at, 1'b0,
                erasing && $time >= win_until, tog2, 2'b00};
    else rd_val = mem[addr_in[7:0]];
    drv = 1'b1;
  end

  always @(posedge oe_n_in) begin
    if (busy_now() && addr_in[21:20] == bank) begin
      tog1 = ~tog1;
      if (erasing && sel[addr_in[15:12]]) tog2 = ~tog2;
    end
    last = rd_val;
    drv = 1'b0;
  end

  // A released bus shows the inverse of the last byte, never a held value.
  assign dq_out = drv ? rd_val : ~last;
endmodule // flash_dev_model

// [bench/flash_poll_host_tb.sv]
/*
  Self-checking bench for the flash polling host: user commands in, the
  behavioural flash model on the pins. Assumes the model's ns timing.
*/
`timescale 1ns/10ps

module flash_poll_host_tb;
  import flash_host_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic pause_in = 1'b0;
  op_e cmd_op_in = OP_READ;
  logic [21:0] cmd_addr_in = '0;
  logic [7:0] cmd_data_in = '0;
  logic cmd_ready_out, done_out, fail_out, late_out, window_out, dev_ready_out;
  logic [7:0] rdata_out, host_dq, dev_dq, dq_bus;
  logic [21:0] flash_addr;
  logic host_oe, we_n, oe_n, ce_n, rb_n;
  int fail_count = 0;
  int checks_done = 0;

  always #10 clk_in = ~clk_in;
  assign dq_bus = host_oe ? host_dq : dev_dq;

  flash_poll_host DUT (.clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .pause_in(pause_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .fail_out(fail_out), .late_out(late_out),
    .window_out(window_out), .rdata_out(rdata_out), .dev_ready_out(dev_ready_out),
    .flash_addr_out(flash_addr), .flash_dq_out(host_dq), .flash_dq_oe_out(host_oe),
    .flash_dq_in(dq_bus), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n), .flash_ce_n_out(ce_n),
    .ready_busy_n_in(rb_n));

  flash_dev_model DEV (.addr_in(flash_addr), .dq_in(dq_bus), .we_n_in(we_n), .oe_n_in(oe_n),
    .ce_n_in(ce_n), .dq_out(dev_dq), .ready_busy_n_out(rb_n));

  task automatic tally_and_finish();
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One command: wait for ready, hold valid across the taking edge, await done.
  task automatic run(input op_e op, input logic [21:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready_out !== 1'b1) begin
      @(posedge clk_in) #2;
      if (++n > 5000) begin
        fail_count++;
        tally_and_finish();
      end
    end
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_data_in = d;
    cmd_valid_in = 1'b1;
    @(posedge clk_in) #2;
    cmd_valid_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1) begin
      @(posedge clk_in) #2;
      if (++n > 5000) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask

  task automatic idle(input int cycles);
    repeat (cycles) @(posedge clk_in);
    #2;
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    #2 reset_in = 1'b0;
    idle(2);
    run(OP_READ, 22'h000012, 8'h00);
    check(rdata_out, 8'h48);
    run(OP_PROGRAM, 22'h000012, 8'h40);
    check({7'h00, fail_out}, 8'h00);
    idle(5);
    check({7'h00, dev_ready_out}, 8'h01);
    run(OP_READ, 22'h000012, 8'h00);
    check(rdata_out, 8'h40);
    run(OP_PROGRAM, 22'h000013, 8'hFF);
    check({7'h00, fail_out}, 8'h01);
    run(OP_READ, 22'h000013, 8'h00);
    check(rdata_out, 8'h49);
    run(OP_PROGRAM, 22'h000F20, 8'h00);
    check({7'h00, fail_out}, 8'h00);
    run(OP_READ, 22'h000F20, 8'h00);
    check(rdata_out, 8'h7A);
    run(OP_ADD_SECTOR, 22'h004000, 8'h00);
    check({7'h00, late_out}, 8'h01);
    run(OP_SECTOR_ERASE, 22'h003000, 8'h00);
    check({6'h00, window_out, dev_ready_out}, 8'h00);
    run(OP_ADD_SECTOR, 22'h004000, 8'h00);
    check({6'h00, late_out, window_out}, 8'h00);
    idle(120);
    run(OP_ADD_SECTOR, 22'h005000, 8'h00);
    check({6'h00, late_out, window_out}, 8'h03);
    run(OP_READ, 22'h004000, 8'h00);
    check({7'h00, late_out}, 8'h01);
    run(OP_WAIT, 22'h004000, 8'h00);
    check({7'h00, fail_out}, 8'h00);
    idle(5);
    check({7'h00, dev_ready_out}, 8'h01);
    run(OP_READ, 22'h000012, 8'h00);
    check(rdata_out, 8'hFF);
    run(OP_PROGRAM, 22'h000030, 8'h11);
    run(OP_CHIP_ERASE, 22'h000000, 8'h00);
    check({7'h00, fail_out}, 8'h00);
    run(OP_READ, 22'h000030, 8'h00);
    check(rdata_out, 8'hFF);
    // Polling is held off while paused and restarts with a fresh pair of reads.
    pause_in = 1'b1;
    fork
      run(OP_PROGRAM, 22'h000031, 8'h24);
      begin
        idle(100);
        check({7'h00, oe_n}, 8'h01);
        pause_in = 1'b0;
      end
    join
    check({7'h00, fail_out}, 8'h00);
    run(OP_READ, 22'h000031, 8'h00);
    check(rdata_out, 8'h24);
    run(OP_RESET, 22'h000000, 8'h00);
    check({7'h00, fail_out}, 8'h00);
    tally_and_finish();
  end
endmodule // flash_poll_host_tb
